// ==== brf_pkg.sv ====
`default_nettype none
package brf_pkg;
   // ---------------------------------------------------------------
   // Storage sizes
   // ---------------------------------------------------------------
   localparam int BRF_GPR_PHYS = 30;
   localparam int BRF_SAVED_N = 5;
   localparam int BRF_REG_W = 32;

   // ---------------------------------------------------------------
   // Status word fields
   // ---------------------------------------------------------------
   localparam int BRF_FLAG_LSB = 28;
   localparam int BRF_IRQ_BLOCK_BIT = 7;
   localparam int BRF_FIQ_BLOCK_BIT = 6;
   localparam int BRF_STATE_BIT = 5;
   localparam logic [31:0] BRF_PSR_RESET = 32'h0000_00D3;
   localparam logic [31:0] BRF_RESET_VECTOR = 32'h0000_0000;
   localparam logic [31:0] BRF_STEP_WIDE = 32'h0000_0004;
   localparam logic [31:0] BRF_STEP_COMPACT = 32'h0000_0002;

   // ---------------------------------------------------------------
   // Mode encodings
   // ---------------------------------------------------------------
   localparam logic [4:0] BRF_MODE_USR = 5'h10;
   localparam logic [4:0] BRF_MODE_FIQ = 5'h11;
   localparam logic [4:0] BRF_MODE_IRQ = 5'h12;
   localparam logic [4:0] BRF_MODE_SVC = 5'h13;
   localparam logic [4:0] BRF_MODE_ABT = 5'h17;
   localparam logic [4:0] BRF_MODE_UND = 5'h1B;
   localparam logic [4:0] BRF_MODE_SYS = 5'h1F;

   // ---------------------------------------------------------------
   // Register banks
   // ---------------------------------------------------------------
   localparam logic [2:0] BRF_BANK_USR = 3'h0;
   localparam logic [2:0] BRF_BANK_FIQ = 3'h1;
   localparam logic [2:0] BRF_BANK_IRQ = 3'h2;
   localparam logic [2:0] BRF_BANK_SVC = 3'h3;
   localparam logic [2:0] BRF_BANK_ABT = 3'h4;
   localparam logic [2:0] BRF_BANK_UND = 3'h5;
   localparam logic [4:0] BRF_FIQ_BASE = 5'h07;
   localparam logic [4:0] BRF_PAIR_BASE = 5'h12;

   // ---------------------------------------------------------------
   // Carriers
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {BRF_SIZE_BYTE, BRF_SIZE_HALF, BRF_SIZE_WORD} brf_size_t;

   typedef struct packed {
      logic take;
      logic [4:0] mode;
      logic [31:0] vector;
   } brf_exc_req_t;

   typedef struct packed {
      logic valid;
      brf_size_t size;
      logic [31:0] addr;
      logic [31:0] store_data;
   } brf_mem_req_t;

   typedef struct packed {
      logic [BRF_GPR_PHYS-1:0][31:0] gpr;
      logic [31:0] pc;
      logic [31:0] status;
      logic [BRF_SAVED_N-1:0][31:0] saved;
      logic [31:0] rd_a;
      logic [31:0] rd_b;
      logic access_fault;
      logic [31:0] mem_word_addr;
      logic [31:0] st_lanes;
      logic [3:0] st_ben;
      logic [31:0] ld_data;
      logic align_fault;
   } brf_state_t;
endpackage
`default_nettype wire

// ==== brf_core_state.sv ====
// Behaviour
// - Fetch words wide, halfwords compact, pc bit1
// - State change keeps mode and registers
// - Branch-exchange operand bit0 selects state
// - Exception return restores compact state
// - Exception: wide state, save pc, vector
// - Big endian: byte 0 on 31..24
// - Little endian: byte 0 on 7..0
// - Bytes numbered upward, four per word
// - Byte/half/word accesses, aligned only
// - Seven operating modes
// - Mode changes by software or exceptions
// - 37 registers: 31 general, six status
// - Wide state: sixteen registers plus status words
// - Branch-with-link copies pc into link
// - Program counter low bits read zero
// - Fast interrupt banks registers 8 to 14
// - Other exception modes bank 13 and 14
// - Compact registers share wide physical registers
// - Compact high registers need special variants, except 13 and 14
// - Status word holds flags and mode
// - Five-bit mode field encodings
// - Two bits block normal and fast interrupts
// - State bit drives external indicator
`timescale 1ns/100ps
`default_nettype none
module brf_core_state
   import brf_pkg::*;
(
   input wire logic clock_i, // Core clock, 40 MHz
   input wire logic rstn_i, // Synchronous reset, active low
   input wire logic big_endian_i, // Byte lane order select
   input wire logic [3:0] rd_a_idx_i, // Read port A register number
   input wire logic [3:0] rd_b_idx_i, // Read port B register number
   input wire logic wr_en_i, // Register write strobe
   input wire logic [3:0] wr_idx_i, // Register write number
   input wire logic [31:0] wr_data_i, // Register write data
   input wire logic hi_access_i, // Special move/compare/add variant
   input wire logic flags_wr_i, // Condition flag update strobe
   input wire logic [3:0] flags_i, // New condition flags
   input wire logic psr_wr_i, // Software status word write
   input wire logic psr_wr_saved_i, // Write targets saved status word
   input wire logic [31:0] psr_wr_data_i, // Status word write data
   input wire logic fetch_next_i, // Step program counter
   input wire logic branch_exchange_op_i, // Branch with state exchange
   input wire logic [31:0] exchange_target_i, // Exchange operand register
   input wire logic branch_with_link_op_i, // Branch saving return address
   input wire logic [31:0] link_target_i, // Branch-with-link target
   input wire brf_exc_req_t exc_req_i, // Exception entry request
   input wire logic exc_return_i, // Exception return strobe
   input wire logic [31:0] ret_addr_i, // Exception return address
   input wire brf_mem_req_t mem_req_i, // Data access request
   input wire logic [31:0] load_lanes_i, // Data lines from memory
   output logic [31:0] rd_a_data_o, // Read port A data
   output logic [31:0] rd_b_data_o, // Read port B data
   output logic access_fault_o, // Last access refused in compact state
   output logic [31:0] pc_o, // Program counter
   output logic [31:0] fetch_addr_o, // Fetch address, aligned
   output logic fetch_half_sel_o, // Upper halfword in compact state
   output logic fetch_wide_o, // Fetch is a full word
   output logic [31:0] current_status_word_o, // Current status word
   output logic [31:0] saved_status_word_o, // Saved status word of mode
   output logic state_indicator_pin_o, // High in compact state
   output logic privileged_o, // Mode is not user
   output logic mode_valid_o, // Mode field holds a defined mode
   output logic irq_block_o, // Normal interrupts blocked
   output logic fiq_block_o, // Fast interrupts blocked
   output logic [31:0] mem_word_addr_o, // Word address of access
   output logic [31:0] store_lanes_o, // Data lines to memory
   output logic [3:0] byte_en_o, // Active byte lanes
   output logic [31:0] load_data_o, // Loaded value, zero-extended
   output logic align_fault_o // Misaligned access refused
);

   // ---------------------------------------------------------------
   // Mode decode helpers
   // ---------------------------------------------------------------
   function automatic logic valid_mode(input logic [4:0] m);
      valid_mode = (m == BRF_MODE_USR) || (m == BRF_MODE_FIQ) || (m == BRF_MODE_IRQ) ||
                   (m == BRF_MODE_SVC) || (m == BRF_MODE_ABT) || (m == BRF_MODE_UND) ||
                   (m == BRF_MODE_SYS);
   endfunction

   function automatic logic [2:0] bank_of(input logic [4:0] m);
      case (m)
         BRF_MODE_FIQ: bank_of = BRF_BANK_FIQ;
         BRF_MODE_IRQ: bank_of = BRF_BANK_IRQ;
         BRF_MODE_SVC: bank_of = BRF_BANK_SVC;
         BRF_MODE_ABT: bank_of = BRF_BANK_ABT;
         BRF_MODE_UND: bank_of = BRF_BANK_UND;
         default: bank_of = BRF_BANK_USR;
      endcase
   endfunction

   // Physical slot of a visible register in a bank
   function automatic logic [4:0] phys_of(input logic [2:0] bank, input logic [3:0] idx);
      logic [4:0] p;
      p = {1'b0, idx};
      if (bank == BRF_BANK_FIQ && idx >= 4'h8 && idx <= 4'hE) begin
         p = BRF_FIQ_BASE + {1'b0, idx};
      end else if (bank >= BRF_BANK_IRQ && (idx == 4'hD || idx == 4'hE)) begin
         p = BRF_PAIR_BASE + {1'b0, bank, 1'b0} + {4'h0, ~idx[0]};
      end
      phys_of = p;
   endfunction

   function automatic logic [31:0] align_pc(input logic [31:0] a, input logic compact);
      align_pc = compact ? {a[31:1], 1'b0} : {a[31:2], 2'b00};
   endfunction

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   brf_state_t state_reg;
   brf_state_t state_next;
   logic [2:0] cur_bank;
   logic [2:0] exc_bank;
   logic [4:0] exc_mode;
   logic compact;
   logic priv;
   logic [1:0] lane;
   logic [31:0] ld_shift;

   // Compact state reaches high registers other than 13 and 14 only through special variants
   function automatic logic reachable(input logic c, input logic [3:0] idx, input logic hi);
      reachable = !c || !idx[3] || idx == 4'hD || idx == 4'hE || hi;
   endfunction

   function automatic logic [31:0] read_reg(input brf_state_t s, input logic [2:0] bank,
                                            input logic [3:0] idx);
      if (idx == 4'hF) begin
         read_reg = s.pc;
      end else begin
         read_reg = s.gpr[phys_of(bank, idx)];
      end
   endfunction

   // ---------------------------------------------------------------
   // Next-state logic
   // ---------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      cur_bank = bank_of(state_reg.status[4:0]);
      compact = state_reg.status[BRF_STATE_BIT];
      priv = state_reg.status[4:0] != BRF_MODE_USR;
      lane = 2'b00;
      ld_shift = 32'h0000_0000;
      exc_mode = BRF_MODE_SVC;
      exc_bank = BRF_BANK_SVC;

      // Register reads for the current bank
      state_next.access_fault = 1'b0;
      state_next.rd_a = 32'h0000_0000;
      state_next.rd_b = 32'h0000_0000;
      if (reachable(compact, rd_a_idx_i, hi_access_i)) begin
         state_next.rd_a = read_reg(state_reg, cur_bank, rd_a_idx_i);
      end else begin
         state_next.access_fault = 1'b1;
      end
      if (reachable(compact, rd_b_idx_i, hi_access_i)) begin
         state_next.rd_b = read_reg(state_reg, cur_bank, rd_b_idx_i);
      end else begin
         state_next.access_fault = 1'b1;
      end

      // Flags and software status writes; current-word writes leave the state bit, saved-word writes take it whole
      if (flags_wr_i) begin
         state_next.status[31:BRF_FLAG_LSB] = flags_i;
      end
      if (psr_wr_i && !psr_wr_saved_i) begin
         state_next.status[31:BRF_FLAG_LSB] = psr_wr_data_i[31:BRF_FLAG_LSB];
         if (priv) begin
            state_next.status[BRF_IRQ_BLOCK_BIT] = psr_wr_data_i[BRF_IRQ_BLOCK_BIT];
            state_next.status[BRF_FIQ_BLOCK_BIT] = psr_wr_data_i[BRF_FIQ_BLOCK_BIT];
            state_next.status[4:0] = psr_wr_data_i[4:0];
         end
      end else if (psr_wr_i && priv && cur_bank != BRF_BANK_USR) begin
         state_next.saved[cur_bank - 3'h1] = psr_wr_data_i;
      end

      // General register write
      if (wr_en_i && reachable(compact, wr_idx_i, hi_access_i)) begin
         if (wr_idx_i == 4'hF) begin
            state_next.pc = align_pc(wr_data_i, compact);
         end else begin
            state_next.gpr[phys_of(cur_bank, wr_idx_i)] = wr_data_i;
         end
      end else if (wr_en_i) begin
         state_next.access_fault = 1'b1;
      end

      // Program counter flow, lowest priority first
      if (fetch_next_i) begin
         state_next.pc = state_reg.pc + (compact ? BRF_STEP_COMPACT : BRF_STEP_WIDE);
      end
      if (branch_with_link_op_i) begin
         state_next.gpr[phys_of(cur_bank, 4'hE)] = state_reg.pc;
         state_next.pc = align_pc(link_target_i, compact);
      end
      if (branch_exchange_op_i) begin
         state_next.status[BRF_STATE_BIT] = exchange_target_i[0];
         state_next.pc = align_pc(exchange_target_i, exchange_target_i[0]);
      end
      if (exc_return_i) begin
         if (cur_bank != BRF_BANK_USR) begin
            state_next.status = state_reg.saved[cur_bank - 3'h1];
         end
         state_next.pc = align_pc(ret_addr_i, state_next.status[BRF_STATE_BIT]);
      end
      if (exc_req_i.take) begin
         if (valid_mode(exc_req_i.mode) && exc_req_i.mode != BRF_MODE_USR &&
             exc_req_i.mode != BRF_MODE_SYS) begin
            exc_mode = exc_req_i.mode;
         end
         exc_bank = bank_of(exc_mode);
         state_next.saved[exc_bank - 3'h1] = state_reg.status;
         state_next.gpr[phys_of(exc_bank, 4'hE)] = state_reg.pc;
         state_next.status[4:0] = exc_mode;
         state_next.status[BRF_STATE_BIT] = 1'b0;
         state_next.status[BRF_IRQ_BLOCK_BIT] = 1'b1;
         if (exc_mode == BRF_MODE_FIQ) begin
            state_next.status[BRF_FIQ_BLOCK_BIT] = 1'b1;
         end
         state_next.pc = align_pc(exc_req_i.vector, 1'b0);
      end

      // Data access byte lanes
      state_next.align_fault = 1'b0;
      state_next.st_ben = 4'h0;
      state_next.st_lanes = 32'h0000_0000;
      state_next.ld_data = 32'h0000_0000;
      state_next.mem_word_addr = {mem_req_i.addr[31:2], 2'b00};
      if (mem_req_i.valid) begin
         case (mem_req_i.size)
            BRF_SIZE_BYTE: begin
               lane = big_endian_i ? ~mem_req_i.addr[1:0] : mem_req_i.addr[1:0];
               state_next.st_ben = 4'h1 << lane;
               state_next.st_lanes = {4{mem_req_i.store_data[7:0]}};
               ld_shift = load_lanes_i >> {lane, 3'b000};
               state_next.ld_data = {24'h00_0000, ld_shift[7:0]};
            end
            BRF_SIZE_HALF: begin
               if (mem_req_i.addr[0]) begin
                  state_next.align_fault = 1'b1;
               end else if (big_endian_i ^ mem_req_i.addr[1]) begin
                  state_next.st_ben = 4'hC;
                  state_next.st_lanes = {2{mem_req_i.store_data[15:0]}};
                  state_next.ld_data = {16'h0000, load_lanes_i[31:16]};
               end else begin
                  state_next.st_ben = 4'h3;
                  state_next.st_lanes = {2{mem_req_i.store_data[15:0]}};
                  state_next.ld_data = {16'h0000, load_lanes_i[15:0]};
               end
            end
            BRF_SIZE_WORD: begin
               if (mem_req_i.addr[1:0] != 2'b00) begin
                  state_next.align_fault = 1'b1;
               end else begin
                  state_next.st_ben = 4'hF;
                  state_next.st_lanes = mem_req_i.store_data;
                  state_next.ld_data = load_lanes_i;
               end
            end
            default: begin
               state_next.align_fault = 1'b1;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------
   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         state_reg <= '0;
         state_reg.status <= BRF_PSR_RESET;
         state_reg.pc <= BRF_RESET_VECTOR;
      end else begin
         state_reg <= state_next;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign rd_a_data_o = state_reg.rd_a;
   assign rd_b_data_o = state_reg.rd_b;
   assign access_fault_o = state_reg.access_fault;
   assign pc_o = state_reg.pc;
   assign fetch_wide_o = !state_reg.status[BRF_STATE_BIT];
   assign fetch_addr_o = {state_reg.pc[31:2], 2'b00};
   assign fetch_half_sel_o = state_reg.status[BRF_STATE_BIT] & state_reg.pc[1];
   assign current_status_word_o = state_reg.status;
   assign saved_status_word_o = (cur_bank == BRF_BANK_USR) ? 32'h0000_0000 :
                                state_reg.saved[cur_bank - 3'h1];
   assign state_indicator_pin_o = state_reg.status[BRF_STATE_BIT];
   assign privileged_o = state_reg.status[4:0] != BRF_MODE_USR;
   assign mode_valid_o = valid_mode(state_reg.status[4:0]);
   assign irq_block_o = state_reg.status[BRF_IRQ_BLOCK_BIT];
   assign fiq_block_o = state_reg.status[BRF_FIQ_BLOCK_BIT];
   assign mem_word_addr_o = state_reg.mem_word_addr;
   assign store_lanes_o = state_reg.st_lanes;
   assign byte_en_o = state_reg.st_ben;
   assign load_data_o = state_reg.ld_data;
   assign align_fault_o = state_reg.align_fault;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   AST_BX_STATE: assert property (@(posedge clock_i) disable iff (!rstn_i)
      (branch_exchange_op_i && !exc_req_i.take && !exc_return_i) |=>
      (state_indicator_pin_o == $past(exchange_target_i[0])))
      else $error("exchange did not follow operand bit 0");
   AST_BX_MODE: assert property (@(posedge clock_i) disable iff (!rstn_i)
      (branch_exchange_op_i && !exc_req_i.take && !exc_return_i && !psr_wr_i) |=>
      (current_status_word_o[4:0] == $past(current_status_word_o[4:0])))
      else $error("state change altered the mode");
   AST_EXC_ENTRY: assert property (@(posedge clock_i) disable iff (!rstn_i)
      exc_req_i.take |=> (!state_indicator_pin_o && irq_block_o &&
      pc_o == {$past(exc_req_i.vector[31:2]), 2'b00}))
      else $error("exception entry did not force wide state and vector");
   AST_EXC_LINK: assert property (@(posedge clock_i) disable iff (!rstn_i)
      exc_req_i.take |=>
      (state_reg.gpr[phys_of(bank_of(current_status_word_o[4:0]), 4'hE)] == $past(pc_o)))
      else $error("exception link register not loaded");
   AST_EXC_VALID: assert property (@(posedge clock_i) disable iff (!rstn_i)
      exc_req_i.take |=> (mode_valid_o && privileged_o))
      else $error("exception produced an undefined mode");
   AST_RET_STATE: assert property (@(posedge clock_i) disable iff (!rstn_i)
      (exc_return_i && !exc_req_i.take && privileged_o && saved_status_word_o[5] &&
      $past(exc_req_i.take)) |=> state_indicator_pin_o)
      else $error("return did not resume compact state");
   AST_PC_ALIGN: assert property (@(posedge clock_i) disable iff (!rstn_i)
      state_indicator_pin_o ? (pc_o[0] == 1'b0) : (pc_o[1:0] == 2'b00))
      else $error("program counter low bits not zero");
   AST_BL_LINK: assert property (@(posedge clock_i) disable iff (!rstn_i)
      (branch_with_link_op_i && !branch_exchange_op_i && !exc_req_i.take && !exc_return_i &&
      !psr_wr_i) ##1 (rd_a_idx_i == 4'hE && !exc_req_i.take) |=> (rd_a_data_o == $past(pc_o, 2)))
      else $error("link register did not receive program counter");
   AST_BE_LANE: assert property (@(posedge clock_i) disable iff (!rstn_i)
      (mem_req_i.valid && mem_req_i.size == BRF_SIZE_BYTE && big_endian_i &&
      mem_req_i.addr[1:0] == 2'b00) |=> (byte_en_o == 4'h8))
      else $error("big endian byte 0 not on top lane");
   AST_LE_LANE: assert property (@(posedge clock_i) disable iff (!rstn_i)
      (mem_req_i.valid && mem_req_i.size == BRF_SIZE_BYTE && !big_endian_i &&
      mem_req_i.addr[1:0] == 2'b00) |=> (byte_en_o == 4'h1))
      else $error("little endian byte 0 not on bottom lane");
   AST_ALIGN: assert property (@(posedge clock_i) disable iff (!rstn_i)
      (mem_req_i.valid && mem_req_i.size == BRF_SIZE_WORD && mem_req_i.addr[1:0] != 2'b00)
      |=> (align_fault_o && byte_en_o == 4'h0))
      else $error("misaligned word not refused");
endmodule // brf_core_state
`default_nettype wire

// ==== brf_mem_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// ---------------------------------------------------------------
// Memory side: each word shows a fixed pattern plus its address
// ---------------------------------------------------------------
module brf_mem_model (
   input wire logic [31:0] addr_i, // Byte address of access
   output logic [31:0] lanes_o // Data lines for the addressed word
);
   assign lanes_o = 32'h4433_2211 + {addr_i[31:2], 2'b00};
endmodule // brf_mem_model
`default_nettype wire

// ==== tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb;
   import brf_pkg::*;
   logic clk = 0, rstn = 0, be = 0, wr = 0, hi = 0, fw = 0, pw = 0, fn = 0, xchg = 0, bwl = 0;
   logic er = 0, ps = 0;
   logic [3:0] ra = 0, wi = 0, fl = 0;
   logic [31:0] d = 0, lanes, rd_a, pc, csw, ssw, wa, sl, ld;
   logic state, priv, mv, ib, fb, af, hs, wide, alf;
   logic [3:0] ben;
   logic [31:0] fa, rb;
   brf_exc_req_t exc = '0;
   brf_mem_req_t mr = '0;
   int failures = 0, comparisons = 0, cycles = 0;
   brf_mem_model mem_u (.addr_i(mr.addr), .lanes_o(lanes));
   brf_core_state dut_u (.clock_i(clk), .rstn_i(rstn), .big_endian_i(be), .rd_a_idx_i(ra),
      .rd_b_idx_i(4'hd), .wr_en_i(wr), .wr_idx_i(wi), .wr_data_i(d), .hi_access_i(hi),
      .flags_wr_i(fw), .flags_i(fl), .psr_wr_i(pw), .psr_wr_saved_i(ps),
      .psr_wr_data_i(d), .fetch_next_i(fn), .branch_exchange_op_i(xchg),
      .exchange_target_i(d), .branch_with_link_op_i(bwl), .link_target_i(d),
      .exc_req_i(exc), .exc_return_i(er),
      .ret_addr_i(d), .mem_req_i(mr), .load_lanes_i(lanes), .rd_a_data_o(rd_a),
      .rd_b_data_o(rb), .access_fault_o(af), .pc_o(pc), .fetch_addr_o(fa),
      .fetch_half_sel_o(hs), .fetch_wide_o(wide), .current_status_word_o(csw),
      .saved_status_word_o(ssw), .state_indicator_pin_o(state), .privileged_o(priv),
      .mode_valid_o(mv), .irq_block_o(ib), .fiq_block_o(fb), .mem_word_addr_o(wa),
      .store_lanes_o(sl), .byte_en_o(ben), .load_data_o(ld), .align_fault_o(alf));
   initial begin
      forever #12.5 clk = ~clk;
   end
   task automatic tick; @(negedge clk); endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      comparisons++;
      if (s !== e) begin
         failures++;
         $display("unexpected at %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic rd(input logic [3:0] i, input logic [31:0] e);
      ra = i; tick; chk(rd_a, e);
   endtask
   task automatic wreg(input logic [3:0] i, input logic [31:0] v);
      wi = i; d = v; wr = 1; tick; wr = 0; tick;
   endtask
   task automatic take(input logic [4:0] m, input logic [31:0] v);
      exc = '{1'b1, m, v}; tick; exc = '0;
   endtask
   task automatic ret; d = 32'h40; er = 1; tick; er = 0; endtask
   task automatic t_reset;
      chk(csw, 32'h0000_00d3);
      chk(pc, 32'h0); chk(state, 1'b0); chk(priv, 1'b1);
      $display("test reset done");
   endtask
   task automatic t_bank;
      fn = 1; tick; tick; fn = 0; chk(pc, 32'h8); chk(fa, 32'h8);
      wreg(4'hd, 32'h55); wreg(4'h8, 32'h88);
      take(5'h12, 32'h18); chk(csw[4:0], 5'h12); chk(pc, 32'h18);
      chk(ssw, 32'h0000_00d3); chk(ib, 1'b1);
      chk(rb, 32'h55);
      rd(4'he, 32'h8); rd(4'hd, 32'h0); rd(4'h8, 32'h88);
      chk(rb, 32'h0);
      ret; chk(csw, 32'h0000_00d3); rd(4'hd, 32'h55);
      $display("test bank done");
   endtask
   task automatic t_state;
      d = 32'h101; xchg = 1; tick; xchg = 0;
      chk(state, 1'b1); chk(pc, 32'h100); chk(csw[5:0], 6'h33);
      rd(4'hd, 32'h55);
      fn = 1; tick; fn = 0; chk(pc, 32'h102); chk(hs, 1'b1); chk(wide, 1'b0);
      ra = 4'h8; tick; chk(rd_a, 32'h0); chk(af, 1'b1);
      hi = 1; rd(4'h8, 32'h88); hi = 0;
      take(5'h17, 32'h10); chk(state, 1'b0); chk(wide, 1'b1);
      ret; chk(state, 1'b1);
      d = 32'h200; xchg = 1; tick; xchg = 0; chk(state, 1'b0); chk(pc, 32'h200);
      $display("test state done");
   endtask
   task automatic t_fiq;
      take(5'h11, 32'h1c); chk(fb, 1'b1);
      wreg(4'h8, 32'h99); rd(4'h8, 32'h99);
      d = 32'h4000_00d3; pw = 1; ps = 1; tick; pw = 0; ps = 0;
      chk(ssw, 32'h4000_00d3);
      ret; chk(csw, 32'h4000_00d3); rd(4'h8, 32'h88);
      d = 32'h300; bwl = 1; tick; bwl = 0; chk(pc, 32'h300); rd(4'he, 32'h40);
      $display("test fiq done");
   endtask
   task automatic t_mem;
      logic [4:0] b = 5'b10001;
      logic [1:0] sz[5] = '{0, 0, 2, 1, 1};
      logic [31:0] ad[5] = '{0, 0, 4, 1, 2};
      logic [3:0] eb[5] = '{4'h8, 4'h1, 4'hf, 4'h0, 4'h3};
      logic [31:0] el[5] = '{32'h44, 32'h11, 32'h4433_2215, 32'h0, 32'h2211};
      logic [31:0] es[5] = '{32'h8888_8888, 32'h8888_8888, 32'h5566_7788, 32'h0, 32'h7788_7788};
      logic [31:0] ew[5] = '{32'h0, 32'h0, 32'h4, 32'h0, 32'h0};
      for (int i = 0; i < 5; i++) begin
         be = b[i]; mr = '{1'b1, brf_size_t'(sz[i]), ad[i], 32'h5566_7788}; tick;
         chk(ben, eb[i]); chk(alf, i == 3);
         chk(sl, es[i]); chk(wa, ew[i]);
         if (i != 3) chk(ld, el[i]);
      end
      mr = '0; be = 0;
      $display("test mem done");
   endtask
   task automatic t_user;
      fl = 4'ha; fw = 1; tick; fw = 0; chk(csw[31:28], 4'ha);
      d = 32'h15; pw = 1; tick; chk(mv, 1'b0); chk(ib, 1'b0); chk(fb, 1'b0);
      d = 32'h10; tick; chk(priv, 1'b0); chk(mv, 1'b1);
      d = 32'h13; tick; pw = 0; chk(csw[4:0], 5'h10); chk(ssw, 32'h0);
      $display("test user done");
   endtask
   task automatic end_sim;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 2000) begin
         failures++;
         end_sim;
      end
   end
   initial begin
      repeat (12) tick;
      rstn = 1; tick;
      t_reset; t_bank; t_state; t_fiq; t_mem; t_user;
      end_sim;
   end
endmodule // tb
`default_nettype wire
